// ===== tco_channel_unit.sv
/*
 * Timer channel array: per-channel one-count and capture-plus-one-count
 * counters, output pin controller and an Avalon-MM register slave.
 * Assumes software follows the documented setup order before starting.
 */
`timescale 1ns/1ps
module tco_channel_unit #(
  parameter int N_CH = 8,
  parameter int CW   = 16
) (
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  input  wire logic [7:0]      i_address,
  input  wire logic            i_read,
  input  wire logic            i_write,
  input  wire logic [31:0]     i_writedata,
  output logic      [31:0]     o_readdata,
  output logic                 o_waitrequest,
  input  wire logic [N_CH-1:0] i_timer_in,
  output logic      [N_CH-1:0] o_timer_out,
  output logic      [N_CH-1:0] o_timer_irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // master of a slave channel: nearest even channel below it
  function automatic int master_of(input int ch);
    return (ch - 1) & ~1;
  endfunction : master_of

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : hit

  logic                   wait_q;
  logic                   acc;
  logic                   wr;
  logic [N_CH-1:0]        en;
  logic [N_CH-1:0]        mode_cap;
  logic [N_CH-1:0]        filt_en;
  logic [N_CH-1:0]        outval;
  logic [N_CH-1:0]        outen;
  logic [N_CH-1:0]        outpol;
  logic [N_CH-1:0]        outmode;
  logic [N_CH-1:0]        slave_eff;
  logic [N_CH-1:0]        set_dly;
  logic [N_CH-1:0]        irq;
  logic [N_CH-1:0]        cap_ev;
  logic [N_CH-1:0]        start_hit;
  logic [N_CH-1:0]        stop_hit;
  logic [CW-1:0]          cnt   [N_CH];
  logic [CW-1:0]          data  [N_CH];
  tco_pkg::tco_state_e    st    [N_CH];
  tco_pkg::tco_edge_s     edge_ev [N_CH];
  logic [31:0]            next_rdata;

  // ****************************************************************
  // bus slave: one wait cycle on every access
  // ****************************************************************
  assign acc = (i_read | i_write) & ~wait_q;
  assign wr  = acc & i_write;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wait_q <= 1'b1;
    end else if ((i_read | i_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    next_rdata = tco_pkg::TCO_RD_UNMAPPED;
    if (hit(i_address, tco_pkg::TCO_OFF_STATUS)) begin
      next_rdata[N_CH-1:0] = en;
    end else if (hit(i_address, tco_pkg::TCO_OFF_MODE)) begin
      next_rdata[N_CH-1:0] = mode_cap;
      next_rdata[tco_pkg::TCO_POS_FILT +: N_CH] = filt_en;
    end else if (hit(i_address, tco_pkg::TCO_OFF_OUTVAL)) begin
      next_rdata[N_CH-1:0] = outval;
    end else if (hit(i_address, tco_pkg::TCO_OFF_OUTEN)) begin
      next_rdata[N_CH-1:0] = outen;
    end else if (hit(i_address, tco_pkg::TCO_OFF_OUTPOL)) begin
      next_rdata[N_CH-1:0] = outpol;
    end else if (hit(i_address, tco_pkg::TCO_OFF_OUTMODE)) begin
      next_rdata[N_CH-1:0] = outmode;
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (hit(i_address, tco_pkg::TCO_OFF_DATA + 8'(4 * n))) begin
          next_rdata[CW-1:0] = data[n];
        end
        if (hit(i_address, tco_pkg::TCO_OFF_COUNT + 8'(4 * n))) begin
          next_rdata[CW-1:0] = cnt[n];
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_readdata <= '0;
    end else if (i_read && wait_q) begin
      o_readdata <= next_rdata;
    end
  end

  assign o_waitrequest = wait_q;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_cap <= '0;
      filt_en  <= '0;
      outen    <= '0;
      outpol   <= '0;
      outmode  <= '0;
    end else if (wr) begin
      if (hit(i_address, tco_pkg::TCO_OFF_MODE)) begin
        mode_cap <= i_writedata[N_CH-1:0];
        filt_en  <= i_writedata[tco_pkg::TCO_POS_FILT +: N_CH];
      end
      if (hit(i_address, tco_pkg::TCO_OFF_OUTEN)) begin
        outen <= i_writedata[N_CH-1:0];
      end
      if (hit(i_address, tco_pkg::TCO_OFF_OUTPOL)) begin
        outpol <= i_writedata[N_CH-1:0];
      end
      if (hit(i_address, tco_pkg::TCO_OFF_OUTMODE)) begin
        outmode <= i_writedata[N_CH-1:0];
      end
    end
  end

  // ****************************************************************
  // counters
  // ****************************************************************
  for (genvar g = 0; g < N_CH; g++) begin : g_in
    tco_input_filter u_filt (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_pin     (i_timer_in[g]),
      .i_filt_en (filt_en[g]),
      .o_edge    (edge_ev[g])
    );
  end

  always_comb begin
    for (int n = 0; n < N_CH; n++) begin
      start_hit[n] = wr && hit(i_address, tco_pkg::TCO_OFF_START) && i_writedata[n];
      stop_hit[n]  = wr && hit(i_address, tco_pkg::TCO_OFF_STOP) && i_writedata[n];
      cap_ev[n]    = (st[n] == tco_pkg::TCO_ST_RUN) && mode_cap[n] && edge_ev[n].fall
                     && !stop_hit[n];
    end
  end

  // output settings are not read here, so they cannot disturb counting
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      en  <= '0;
      irq <= '0;
      for (int n = 0; n < N_CH; n++) begin
        st[n]  <= tco_pkg::TCO_ST_IDLE;
        cnt[n] <= tco_pkg::TCO_RST_COUNT;
      end
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        irq[n] <= 1'b0;
        if (stop_hit[n]) begin
          en[n] <= 1'b0;
          st[n] <= tco_pkg::TCO_ST_IDLE;
        end else begin
          unique case (st[n])
            tco_pkg::TCO_ST_IDLE: begin
              if (start_hit[n]) begin
                en[n] <= 1'b1;
                st[n] <= tco_pkg::TCO_ST_WAIT;
              end
            end
            tco_pkg::TCO_ST_WAIT: begin
              if (edge_ev[n].rise) begin
                st[n]  <= tco_pkg::TCO_ST_RUN;
                cnt[n] <= mode_cap[n] ? tco_pkg::TCO_CNT_ZERO : data[n];
              end
            end
            tco_pkg::TCO_ST_RUN: begin
              if (mode_cap[n]) begin
                if (edge_ev[n].fall) begin
                  irq[n] <= 1'b1;
                  st[n]  <= tco_pkg::TCO_ST_WAIT;
                end else begin
                  cnt[n] <= cnt[n] + 1'b1;
                end
              end else if (cnt[n] == tco_pkg::TCO_CNT_ZERO) begin
                irq[n] <= 1'b1;
                cnt[n] <= tco_pkg::TCO_CNT_STOPPED;
                st[n]  <= tco_pkg::TCO_ST_WAIT;
              end else begin
                cnt[n] <= cnt[n] - 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // capture beats a software write in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int n = 0; n < N_CH; n++) begin
        data[n] <= tco_pkg::TCO_RST_DATA;
      end
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (cap_ev[n]) begin
          data[n] <= cnt[n];
        end else if (wr && hit(i_address, tco_pkg::TCO_OFF_DATA + 8'(4 * n))) begin
          data[n] <= i_writedata[CW-1:0];
        end
      end
    end
  end

  assign o_timer_irq = irq;

  // ****************************************************************
  // output controller
  // ****************************************************************
  // channel 0 has no master below it, so it can only toggle
  always_comb begin
    slave_eff[0] = 1'b0;
    for (int n = 1; n < N_CH; n++) begin
      slave_eff[n] = outmode[n];
    end
  end

  // master set arrives one clock late so 0% and 100% duty both work
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      set_dly <= '0;
    end else begin
      set_dly[0] <= 1'b0;
      for (int n = 1; n < N_CH; n++) begin
        set_dly[n] <= irq[master_of(n)];
      end
    end
  end

  // registered config is used, so a change in an interrupt cycle acts after it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      outval <= '0;
    end else begin
      for (int n = 0; n < N_CH; n++) begin
        if (outen[n]) begin
          if (slave_eff[n]) begin
            if (irq[n]) begin
              outval[n] <= outpol[n];
            end else if (set_dly[n]) begin
              outval[n] <= ~outpol[n];
            end
          end else if (irq[n]) begin
            outval[n] <= ~outval[n];
          end
        end else if (wr && hit(i_address, tco_pkg::TCO_OFF_OUTVAL)) begin
          outval[n] <= i_writedata[n];
        end
      end
    end
  end

  assign o_timer_out = outval;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_bus_wait: assert property ((i_read | i_write) && wait_q |=> !wait_q)
    else $error("waitrequest did not drop after one cycle");
  a_read_out: assert property (i_read && wait_q && hit(i_address, tco_pkg::TCO_OFF_OUTVAL)
                               |=> o_readdata[N_CH-1:0] == $past(outval))
    else $error("output read does not show pin level");

  for (genvar g = 0; g < N_CH; g++) begin : g_chk
    a_start_en: assert property (start_hit[g] && !en[g] && !stop_hit[g]
                                 |=> en[g] && st[g] == tco_pkg::TCO_ST_WAIT)
      else $error("start did not enable channel");
    a_wait_hold: assert property (st[g] == tco_pkg::TCO_ST_WAIT && !edge_ev[g].rise
                                  |=> $stable(cnt[g]))
      else $error("count moved before trigger");
    a_one_load: assert property (st[g] == tco_pkg::TCO_ST_WAIT && !mode_cap[g]
                                 && edge_ev[g].rise && !stop_hit[g]
                                 |=> cnt[g] == $past(data[g]) ##1
                                     cnt[g] == $past(cnt[g]) - 1'b1 || irq[g])
      else $error("one-count load or down-count wrong");
    a_one_end: assert property (st[g] == tco_pkg::TCO_ST_RUN && !mode_cap[g]
                                && cnt[g] == tco_pkg::TCO_CNT_ZERO && !stop_hit[g]
                                |=> irq[g] && cnt[g] == tco_pkg::TCO_CNT_STOPPED
                                    && st[g] == tco_pkg::TCO_ST_WAIT)
      else $error("one-count end not handled");
    a_cap_zero: assert property (st[g] == tco_pkg::TCO_ST_WAIT && mode_cap[g]
                                 && edge_ev[g].rise && !stop_hit[g]
                                 |=> cnt[g] == tco_pkg::TCO_CNT_ZERO)
      else $error("capture start did not clear count");
    a_cap_copy: assert property (cap_ev[g] |=> irq[g] && data[g] == $past(cnt[g]))
      else $error("capture value or interrupt missing");
    a_irq_pulse: assert property (irq[g] |=> !irq[g])
      else $error("interrupt longer than one cycle");
    a_toggle: assert property (outen[g] && !slave_eff[g] && irq[g]
                               |=> outval[g] != $past(outval[g]))
      else $error("toggle did not invert output");
    a_reset_prio: assert property (outen[g] && slave_eff[g] && irq[g] && set_dly[g]
                                   |=> outval[g] == $past(outpol[g]))
      else $error("set won over reset");
    a_sw_ignored: assert property (outen[g] && !irq[g] && !(slave_eff[g] && set_dly[g])
                                   |=> $stable(outval[g]))
      else $error("output changed without event");
    a_oe0_hold: assert property (!outen[g]
                                 && !(wr && hit(i_address, tco_pkg::TCO_OFF_OUTVAL))
                                 |=> $stable(outval[g]))
      else $error("event reached disabled output");
  end

  c_one_end:   cover property (st[1] == tco_pkg::TCO_ST_RUN && !mode_cap[1] && irq[1]);
  c_capture:   cover property (cap_ev[1]);
  c_reset_win: cover property (outen[1] && slave_eff[1] && irq[1] && set_dly[1]);
  c_toggle:    cover property (outen[0] && irq[0]);

endmodule : tco_channel_unit

// ===== tco_pkg.sv
/*
 * Package for the timer channel unit: register map, reset values, state
 * and carrier types shared by the channel unit and its input filter.
 * Assumes a single 125 MHz operation clock and a 32-bit Avalon-MM slave.
 */
package tco_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] TCO_OFF_START   = 8'h00;
  localparam logic [7:0] TCO_OFF_STOP    = 8'h04;
  localparam logic [7:0] TCO_OFF_STATUS  = 8'h08;
  localparam logic [7:0] TCO_OFF_MODE    = 8'h0c;
  localparam logic [7:0] TCO_OFF_OUTVAL  = 8'h10;
  localparam logic [7:0] TCO_OFF_OUTEN   = 8'h14;
  localparam logic [7:0] TCO_OFF_OUTPOL  = 8'h18;
  localparam logic [7:0] TCO_OFF_OUTMODE = 8'h1c;
  localparam logic [7:0] TCO_OFF_DATA    = 8'h20;
  localparam logic [7:0] TCO_OFF_COUNT   = 8'h40;

  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int          TCO_POS_FILT    = 8;
  localparam logic [15:0] TCO_CNT_ZERO    = 16'h0000;
  localparam logic [15:0] TCO_CNT_STOPPED = 16'hffff;
  localparam logic [15:0] TCO_RST_COUNT   = 16'hffff;
  localparam logic [15:0] TCO_RST_DATA    = 16'h0000;
  localparam logic [31:0] TCO_RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    TCO_ST_IDLE,
    TCO_ST_WAIT,
    TCO_ST_RUN
  } tco_state_e;

  typedef struct packed {
    logic rise;
    logic fall;
  } tco_edge_s;

endpackage : tco_pkg

// ===== tco_input_filter.sv
/*
 * Timer input conditioning: three-stage synchroniser, optional two-cycle
 * hold filter and edge detector producing one-cycle rise/fall pulses.
 * Assumes i_pin is asynchronous to i_mclk.
 */
`timescale 1ns/1ps
module tco_input_filter (
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  input  wire logic          i_pin,
  input  wire logic          i_filt_en,
  output tco_pkg::tco_edge_s o_edge
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic level;
  logic hold1;
  logic filt_level;
  logic prev;
  logic sel;

  // ****************************************************************
  // synchroniser: sync1 is read only by sync2
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        level <= sync3;
      end
    end
  end

  // ****************************************************************
  // hold filter: two extra cycles of delay
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hold1      <= 1'b0;
      filt_level <= 1'b0;
    end else begin
      hold1 <= level;
      if (level == hold1) begin
        filt_level <= hold1;
      end
    end
  end

  assign sel = i_filt_en ? filt_level : level;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prev   <= 1'b0;
      o_edge <= '0;
    end else begin
      prev        <= sel;
      o_edge.rise <= sel & ~prev;
      o_edge.fall <= ~sel & prev;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_filt_hold:  assert property (level != hold1 |=> $stable(filt_level))
    else $error("filter accepted an unstable level");
  a_edge_pulse: assert property (o_edge.rise |=> !o_edge.rise)
    else $error("edge pulse longer than one cycle");

endmodule : tco_input_filter

// ===== tco_pin_model.sv
/*
 * Far-side model of the timer pins: drives the timer inputs with
 * clock-aligned pulses and counts level changes on each output pin.
 * Assumes one operation clock; input pins idle low between pulses.
 */
`timescale 1ns/1ps
module tco_pin_model #(
  parameter int N_CH = 8
) (
  input  wire logic            i_mclk,
  input  wire logic [N_CH-1:0] i_timer_out,
  output logic      [N_CH-1:0] o_timer_in
);
  logic [N_CH-1:0] last_out = '0;
  int unsigned     n_edges [N_CH];

  initial begin
    o_timer_in = '0;
    foreach (n_edges[k]) n_edges[k] = 0;
  end

  // ****************************************************************
  // output watch: every change counts, so a glitch shows up
  // ****************************************************************
  always @(posedge i_mclk) begin
    for (int k = 0; k < N_CH; k++) begin
      if (i_timer_out[k] !== last_out[k]) n_edges[k]++;
    end
    last_out <= i_timer_out;
  end

  // ****************************************************************
  // input stimulus: pulses of at least two cycles survive the filter
  // ****************************************************************
  task automatic pulse(input logic [N_CH-1:0] mask, input int width);
    @(posedge i_mclk);
    o_timer_in <= o_timer_in | mask;
    repeat (width) @(posedge i_mclk);
    o_timer_in <= o_timer_in & ~mask;
  endtask : pulse
endmodule : tco_pin_model

// ===== tco_channel_unit_test.sv
/*
 * Self-checking bench for the timer channel unit: bus tasks, one task
 * per scenario. Assumes tco_pkg and the pin model tco_pin_model.
 */
`timescale 1ns/1ps
module tco_channel_unit_test;
  localparam int N_CH = 8;
  logic            i_mclk      = 1'b0;
  logic            i_rst       = 1'b1;
  logic [7:0]      i_address   = 8'h00;
  logic            i_read      = 1'b0;
  logic            i_write     = 1'b0;
  logic [31:0]     i_writedata = 32'h0000_0000;
  logic [31:0]     o_readdata;
  logic            o_waitrequest;
  logic [N_CH-1:0] i_timer_in;
  logic [N_CH-1:0] o_timer_out;
  logic [N_CH-1:0] o_timer_irq;
  logic [31:0]     rdata;
  int              num_errors  = 0;
  int              checks_done = 0;
  int              cyc         = 0;
  int              la;
  int              lb;
  int              lc;

  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc <= cyc + 1;

  tco_channel_unit #(.N_CH(N_CH), .CW(16)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_timer_in(i_timer_in),
    .o_timer_out(o_timer_out), .o_timer_irq(o_timer_irq));

  tco_pin_model #(.N_CH(N_CH)) pin (
    .i_mclk(i_mclk), .i_timer_out(o_timer_out), .o_timer_in(i_timer_in));

  // ****************************************************************
  // checking and bus helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic is_rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_address   <= a;
    i_writedata <= d;
    i_read      <= is_rd;
    i_write     <= !is_rd;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    check("bus answer", 32'(n < 20), 32'h1);
    rdata = o_readdata;
    i_read  <= 1'b0;
    i_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b1, a, 32'h0);
  endtask : rd

  // returns one edge after the interrupt, which must be gone by then
  task automatic wait_irq(input int ch, output int lat);
    int t0;
    t0 = cyc;
    do @(posedge i_mclk); while (o_timer_irq[ch] !== 1'b1 && cyc - t0 < 300);
    lat = cyc - t0;
    check("irq seen", 32'(lat < 300), 32'h1);
    @(posedge i_mclk);
    check("irq one cycle", 32'(o_timer_irq[ch]), 32'h0);
  endtask : wait_irq

  task automatic one_run(input logic [7:0] m, input int w, input int ch, output int lat);
    fork
      pin.pulse(m, w);
      wait_irq(ch, lat);
    join
  endtask : one_run

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(tco_pkg::TCO_OFF_COUNT);
    check("count reset", rdata, 32'h0000_ffff);
    rd(tco_pkg::TCO_OFF_DATA);
    check("data reset", rdata, 32'h0000_0000);
    rd(8'h80);
    check("unmapped read", rdata, tco_pkg::TCO_RD_UNMAPPED);
    rd(tco_pkg::TCO_OFF_OUTVAL);
    check("outval reset", rdata, 32'h0000_0000);
  endtask : t_reset

  task automatic t_one_count();
    wr(tco_pkg::TCO_OFF_OUTMODE, 32'h0);
    wr(tco_pkg::TCO_OFF_OUTVAL, 32'h0);
    wr(tco_pkg::TCO_OFF_OUTEN, 32'h1);
    wr(tco_pkg::TCO_OFF_DATA, 32'h5);
    wr(tco_pkg::TCO_OFF_MODE, 32'h0);
    wr(tco_pkg::TCO_OFF_START, 32'h1);
    rd(tco_pkg::TCO_OFF_STATUS);
    check("enabled", 32'(rdata[0]), 32'h1);
    rd(tco_pkg::TCO_OFF_COUNT);
    check("count held", rdata, 32'h0000_ffff);
    one_run(8'h01, 6, 0, la);
    check("toggle 1", 32'(o_timer_out[0]), 32'h1);
    rd(tco_pkg::TCO_OFF_COUNT);
    check("count stopped", rdata, 32'h0000_ffff);
    wr(tco_pkg::TCO_OFF_DATA, 32'h9);
    one_run(8'h01, 6, 0, lb);
    check("count span", 32'(lb - la), 32'h4);
    check("toggle 2", 32'(o_timer_out[0]), 32'h0);
    // stopped first: a filter switch may fake an edge
    wr(tco_pkg::TCO_OFF_STOP, 32'h1);
    wr(tco_pkg::TCO_OFF_MODE, 32'h100);
    wr(tco_pkg::TCO_OFF_START, 32'h1);
    one_run(8'h01, 6, 0, lc);
    check("filter delay", 32'(lc - lb), 32'h2);
    fork
      one_run(8'h01, 6, 0, la);
      begin
        repeat (4) @(posedge i_mclk);
        wr(tco_pkg::TCO_OFF_OUTPOL, 32'hff);
        wr(tco_pkg::TCO_OFF_OUTVAL, 32'h0);
      end
    join
    check("count undisturbed", 32'(la), 32'(lc));
    check("write ignored", 32'(o_timer_out[0]), 32'h0);
  endtask : t_one_count

  task automatic t_capture();
    wr(tco_pkg::TCO_OFF_STOP, 32'h1);
    wr(tco_pkg::TCO_OFF_MODE, 32'h4);
    wr(tco_pkg::TCO_OFF_START, 32'h5);
    one_run(8'h04, 20, 2, la);
    rd(tco_pkg::TCO_OFF_DATA + 8'h08);
    check("high width", 32'(rdata >= 18 && rdata <= 21), 32'h1);
    check("event blocked", 32'(o_timer_out[2]), 32'h0);
    wr(tco_pkg::TCO_OFF_OUTVAL, 32'h4);
    // the pin moves at the edge that takes the write
    @(posedge i_mclk);
    check("write taken", 32'(o_timer_out[2]), 32'h1);
    rd(tco_pkg::TCO_OFF_OUTVAL);
    check("outval pin", 32'(rdata[2]), 32'h1);
  endtask : t_capture

  task automatic t_pwm();
    int e0;
    wr(tco_pkg::TCO_OFF_OUTMODE, 32'h2);
    wr(tco_pkg::TCO_OFF_OUTPOL, 32'h0);
    wr(tco_pkg::TCO_OFF_OUTVAL, 32'h0);
    wr(tco_pkg::TCO_OFF_OUTEN, 32'h3);
    wr(tco_pkg::TCO_OFF_DATA, 32'h3);
    wr(tco_pkg::TCO_OFF_DATA + 8'h04, 32'hc);
    wr(tco_pkg::TCO_OFF_START, 32'h2);
    e0 = pin.n_edges[1];
    fork
      pin.pulse(8'h03, 6);
      begin
        wait_irq(0, la);
        check("set delayed", 32'(o_timer_out[1]), 32'h0);
        @(posedge i_mclk);
        check("set", 32'(o_timer_out[1]), 32'h1);
        wait_irq(1, lb);
        check("reset", 32'(o_timer_out[1]), 32'h0);
      end
    join
    wr(tco_pkg::TCO_OFF_OUTPOL, 32'h2);
    @(posedge i_mclk);
    check("polarity waits", 32'(o_timer_out[1]), 32'h0);
    one_run(8'h03, 6, 1, lb);
    check("swapped set", 32'(o_timer_out[1]), 32'h1);
    wr(tco_pkg::TCO_OFF_OUTPOL, 32'h0);
    wr(tco_pkg::TCO_OFF_DATA + 8'h04, 32'h4);
    one_run(8'h03, 6, 1, lb);
    check("reset wins", 32'(o_timer_out[1]), 32'h0);
    // the pin model counts the last change at this same edge
    @(posedge i_mclk);
    check("slave edges", 32'(pin.n_edges[1] - e0), 32'h4);
  endtask : t_pwm

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_one_count();
    t_capture();
    t_pwm();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    check("watchdog", 32'h1, 32'h0);
    print_verdict();
  end
endmodule : tco_channel_unit_test
